// ---- logic/adaptive_host_port_pkg.sv ----
// Shared constants and types for the adaptive host port
package adaptive_host_port_pkg;

    // Timing: burst and pause length in tone-pair mode
    localparam int CLK_PERIOD_NS     = 20;
    localparam int BURST_TIME_US     = 51000;
    localparam int BURST_CYCLES_DEF  = BURST_TIME_US * 1000 / CLK_PERIOD_NS;
    localparam int CP_BURST_FACTOR   = 2;

    // Register-select line values
    localparam logic REG_DATA        = 1'b0;
    localparam logic REG_CTRL        = 1'b1;

    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [3:0] DATA_RESET = 4'h0;

    // Bus styles seen at the falling edge of chip select
    localparam logic STYLE_STROBE    = 1'b0;
    localparam logic STYLE_SPLIT     = 1'b1;

    // Main control, b3 down to b0
    typedef struct packed {
        logic aux_steer_bit;
        logic irq_en;
        logic receive_mode_select;
        logic tone_output_enable;
    } main_ctrl_t;

    // Auxiliary control, b3 down to b0
    typedef struct packed {
        logic column_sel;
        logic single_tone;
        logic test_mode;
        logic burst_off;
    } aux_ctrl_t;

    // Transceiver flags, b3 down to b0
    typedef struct packed {
        logic steer_absent;
        logic rx_full;
        logic tx_empty;
        logic irq;
    } flags_t;

    // Host pins as sampled
    typedef struct packed {
        logic       cs_n;
        logic       bus_strobe_in;
        logic       rw;
        logic       register_select_line;
        logic [3:0] data;
    } host_pins_t;

    // Burst sequencer, Gray along idle, tone, pause
    typedef enum logic [1:0] {
        BST_IDLE  = 2'b00,
        BST_TONE  = 2'b01,
        BST_PAUSE = 2'b11
    } burst_state_t;

endpackage : adaptive_host_port_pkg

// ---- logic/pin_sync.sv ----
// Two-stage synchroniser for asynchronous host pins
module pin_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         nrst_i,
    // Pins and synchronised copy
    input  wire logic [W-1:0] pins_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= pins_i;
            sync_o <= meta_q;
        end
    end
endmodule : pin_sync

// ---- logic/adaptive_host_port.sv ----
// Adaptive parallel host port and register bank of the tone transceiver
// Functional notes
// - Strobe low at chip-select fall selects data-strobe style with read/write line.
// - Read strobe high at chip-select fall selects separate read and write strobes.
// - Detect multiplexed bus; latch register select and data at matching times.
// - One equivalent internal strobe drives all register operations.
// - Flags keep updating without any host strobe activity.
// - Select 1: write goes to control, read returns transceiver flags.
// - Received digit holds the latest valid code until replaced.
// - Written tone-pair code selects the generated tone pair.
// - Main control b3 set steers exactly the next control write to aux.
// - Event pin is open drain, pulls low only.
// - Main b0 enables transmit tones; low turns all transmit off.
// - Main b1 high call-progress mode, low tone-pair mode.
// - Call-progress mode with interrupt enable: pin follows received tone.
// - Call-progress mode: no new digits, no receive-full events.
// - Tone-pair mode with interrupt enable and aux b1 low: pin low on digit or burst ready; aux b1 high: pin low while steering present.
// - Flags read clears interrupt, receive-full and transmit-empty, with burst on or off.
// - Flags b0 set whenever b1 or b2 is set.
// - Aux b0 low: burst and pause per tone-code write made while the sequencer is idle, then transmit-empty set.
module adaptive_host_port
    import adaptive_host_port_pkg::*;
#(
    parameter int BURST_CYCLES = BURST_CYCLES_DEF
) (
    // Clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       nrst_i,
    // Host bus pins
    input  wire logic       cs_n_i,
    input  wire logic       bus_strobe_in_i,
    input  wire logic       rw_i,
    input  wire logic       register_select_line_i,
    input  wire logic [3:0] data_i,
    output logic      [3:0] data_o,
    output logic            data_oe_o,
    // Open-drain event or tone pin
    output logic            event_or_tone_pin_o,
    output logic            event_or_tone_oe_o,
    // Receiver side
    input  wire logic       digit_valid_i,
    input  wire logic [3:0] digit_code_i,
    input  wire logic       steer_absent_i,
    input  wire logic       cp_tone_i,
    // Generator side
    output logic      [3:0] tone_code_o,
    output logic            tone_on_o,
    output logic            single_tone_o,
    output logic            column_tone_o,
    output logic            cp_mode_o,
    // Detected bus style
    output logic            bus_style_o,
    output logic            bus_mux_o
);
    localparam int CW = $clog2(CP_BURST_FACTOR * BURST_CYCLES + 1);

    // Elaboration check on the burst length
    if (BURST_CYCLES < 2) begin : g_bad_burst
        $error("BURST_CYCLES must be at least 2");
    end

    // Load value of the burst counter for the current mode
    function automatic logic [CW-1:0] burst_len(input logic cp);
        burst_len = cp ? CW'(CP_BURST_FACTOR * BURST_CYCLES - 1) : CW'(BURST_CYCLES - 1);
    endfunction : burst_len

    // Pin synchronisation
    host_pins_t pins_raw;
    host_pins_t pins_s;
    assign pins_raw = '{cs_n: cs_n_i, bus_strobe_in: bus_strobe_in_i, rw: rw_i,
                        register_select_line: register_select_line_i, data: data_i};

    pin_sync #(.W($bits(host_pins_t))) u_sync (
        .clk_sys_i (clk_sys_i),
        .nrst_i    (nrst_i),
        .pins_i    (pins_raw),
        .sync_o    (pins_s)
    );

    // Bus-side state
    logic       cs_prev_q, cs_prev_d;
    logic       stb_prev_q, stb_prev_d;
    logic       style_q, style_d;
    logic       mux_q, mux_d;
    logic       addr_q, addr_d;
    logic       rd_q, rd_d;
    logic       steer_q, steer_d;
    logic [3:0] data_o_d;
    logic       data_oe_d;
    // Registers
    main_ctrl_t main_q, main_d;
    aux_ctrl_t  aux_q, aux_d;
    logic [3:0] code_q, code_d;
    logic [3:0] digit_q, digit_d;
    flags_t     flags_q, flags_d;
    // Burst sequencer
    burst_state_t bst_q, bst_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic       burst_start;
    logic       burst_done;
    // Derived outputs
    logic       tone_on_d;
    logic       pin_low_d;

    // Strobe decode shared by both bus styles
    logic cs_fall, stb_now, rd_now, stb_rise, stb_fall;
    logic wr_done, rd_done, flags_read;
    logic wr_code, wr_main, wr_aux;

    assign cs_fall  = cs_prev_q && !pins_s.cs_n;
    // Equivalent strobe, held off in the chip-select fall cycle until the style settles
    assign stb_now  = !pins_s.cs_n && !cs_fall && (style_q == STYLE_SPLIT
                      ? (!pins_s.bus_strobe_in || !pins_s.rw)
                      : pins_s.bus_strobe_in);
    assign rd_now   = (style_q == STYLE_SPLIT) ? !pins_s.bus_strobe_in : pins_s.rw;
    assign stb_rise = stb_now && !stb_prev_q;
    assign stb_fall = !stb_now && stb_prev_q;
    assign wr_done  = stb_fall && !rd_q;
    assign rd_done  = stb_fall && rd_q;
    assign flags_read = rd_done && (addr_q == REG_CTRL);
    assign wr_code  = wr_done && (addr_q == REG_DATA);
    assign wr_main  = wr_done && (addr_q == REG_CTRL) && !steer_q;
    assign wr_aux   = wr_done && (addr_q == REG_CTRL) && steer_q;

    // Bus style detection, address latch and read data
    always_comb begin
        cs_prev_d  = pins_s.cs_n;
        stb_prev_d = stb_now;
        style_d    = style_q;
        mux_d      = mux_q;
        addr_d     = addr_q;
        rd_d       = rd_q;
        if (cs_fall) begin
            style_d = pins_s.bus_strobe_in ? STYLE_SPLIT : STYLE_STROBE;
            mux_d   = pins_s.bus_strobe_in;
            if (pins_s.bus_strobe_in) begin
                addr_d = pins_s.register_select_line;
            end
        end
        if (stb_rise) begin
            rd_d = rd_now;
            if (!mux_q) begin
                addr_d = pins_s.register_select_line;
            end
        end
        data_oe_d = stb_now && rd_now && !stb_rise;
        data_o_d  = (addr_q == REG_CTRL) ? flags_q : digit_q;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cs_prev_q  <= 1'b0; // Matches the synchroniser reset level, no false fall
            stb_prev_q <= 1'b0;
            style_q    <= STYLE_STROBE;
            mux_q      <= 1'b0;
            addr_q     <= REG_DATA;
            rd_q       <= 1'b0;
            data_o     <= DATA_RESET;
            data_oe_o  <= 1'b0;
        end else begin
            cs_prev_q  <= cs_prev_d;
            stb_prev_q <= stb_prev_d;
            style_q    <= style_d;
            mux_q      <= mux_d;
            addr_q     <= addr_d;
            rd_q       <= rd_d;
            data_o     <= data_o_d;
            data_oe_o  <= data_oe_d;
        end
    end

    // Register writes, steering and flags
    always_comb begin
        main_d  = main_q;
        aux_d   = aux_q;
        code_d  = code_q;
        digit_d = digit_q;
        steer_d = steer_q;
        flags_d = flags_q;
        // Data is latched on the trailing edge of the strobe
        if (wr_code) begin
            code_d = pins_s.data;
        end
        if (wr_main) begin
            main_d  = main_ctrl_t'(pins_s.data);
            steer_d = pins_s.data[3];
        end
        if (wr_aux) begin
            aux_d   = aux_ctrl_t'(pins_s.data);
            steer_d = 1'b0;
        end
        // Clears first so that a same-cycle event wins
        if (flags_read) begin
            flags_d.rx_full  = 1'b0;
            flags_d.tx_empty = 1'b0;
        end
        if (aux_q.burst_off) begin
            flags_d.tx_empty = 1'b0;
        end
        if (burst_done) begin
            flags_d.tx_empty = 1'b1;
        end
        // Receive runs without host activity
        if (digit_valid_i && !main_q.receive_mode_select) begin
            digit_d         = digit_code_i;
            flags_d.rx_full = 1'b1;
        end
        flags_d.steer_absent = steer_absent_i;
        flags_d.irq = flags_d.rx_full || flags_d.tx_empty;
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            main_q  <= main_ctrl_t'(CTRL_RESET);
            aux_q   <= aux_ctrl_t'(CTRL_RESET);
            code_q  <= DATA_RESET;
            digit_q <= DATA_RESET;
            steer_q <= 1'b0;
            flags_q <= flags_t'(DATA_RESET);
        end else begin
            main_q  <= main_d;
            aux_q   <= aux_d;
            code_q  <= code_d;
            digit_q <= digit_d;
            steer_q <= steer_d;
            flags_q <= flags_d;
        end
    end

    // Burst sequencer: equal tone and pause, doubled in call-progress mode
    assign burst_start = wr_code && !aux_q.burst_off;
    assign burst_done  = (bst_q == BST_PAUSE) && (cnt_q == '0);

    always_comb begin
        bst_d = bst_q;
        cnt_d = cnt_q;
        unique case (bst_q)
            BST_IDLE: begin
                if (burst_start) begin
                    bst_d = BST_TONE;
                    cnt_d = burst_len(main_q.receive_mode_select);
                end
            end
            BST_TONE: begin
                if (cnt_q == '0) begin
                    bst_d = BST_PAUSE;
                    cnt_d = burst_len(main_q.receive_mode_select);
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            BST_PAUSE: begin
                if (cnt_q == '0) begin
                    bst_d = BST_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
        endcase
        if (aux_q.burst_off) begin
            bst_d = BST_IDLE;
            cnt_d = '0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bst_q <= BST_IDLE;
            cnt_q <= '0;
        end else begin
            bst_q <= bst_d;
            cnt_q <= cnt_d;
        end
    end

    // Generator controls and event pin
    always_comb begin
        tone_on_d = main_q.tone_output_enable
                    && (aux_q.burst_off || bst_q == BST_TONE);
        if (main_q.receive_mode_select) begin
            pin_low_d = main_q.irq_en && !cp_tone_i;
        end else if (aux_q.test_mode) begin
            pin_low_d = !flags_q.steer_absent;
        end else begin
            pin_low_d = main_q.irq_en && flags_q.irq;
        end
    end

    always_ff @(posedge clk_sys_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tone_on_o           <= 1'b0;
            tone_code_o         <= DATA_RESET;
            single_tone_o       <= 1'b0;
            column_tone_o       <= 1'b0;
            cp_mode_o           <= 1'b0;
            bus_style_o         <= STYLE_STROBE;
            bus_mux_o           <= 1'b0;
            event_or_tone_pin_o <= 1'b0;
            event_or_tone_oe_o  <= 1'b0;
        end else begin
            tone_on_o           <= tone_on_d;
            tone_code_o         <= code_q;
            single_tone_o       <= aux_q.single_tone;
            column_tone_o       <= aux_q.column_sel;
            cp_mode_o           <= main_q.receive_mode_select;
            bus_style_o         <= style_q;
            bus_mux_o           <= mux_q;
            event_or_tone_pin_o <= 1'b0;
            event_or_tone_oe_o  <= pin_low_d;
        end
    end

    // Checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!nrst_i);

    sequence s_ctrl_write;
        wr_done && (addr_q == REG_CTRL);
    endsequence

    property p_style_strobe;
        cs_fall && !pins_s.bus_strobe_in |=> style_q == STYLE_STROBE ##1 bus_style_o == STYLE_STROBE;
    endproperty
    a_style_strobe: assert property (p_style_strobe) else $error("strobe style not taken");

    property p_style_split;
        cs_fall && pins_s.bus_strobe_in |=> style_q == STYLE_SPLIT && mux_q;
    endproperty
    a_style_split: assert property (p_style_split) else $error("split style not taken");

    property p_mux_addr;
        cs_fall && pins_s.bus_strobe_in |=> addr_q == $past(pins_s.register_select_line);
    endproperty
    a_mux_addr: assert property (p_mux_addr) else $error("multiplexed address not latched");

    property p_code_write;
        wr_code |=> code_q == $past(pins_s.data) ##1 tone_code_o == $past(pins_s.data, 2);
    endproperty
    a_code_write: assert property (p_code_write) else $error("tone code not written");

    property p_aux_steer;
        s_ctrl_write ##0 steer_q |=> aux_q == $past(pins_s.data) && !steer_q;
    endproperty
    a_aux_steer: assert property (p_aux_steer) else $error("aux write not steered");

    property p_digit_rx;
        digit_valid_i && !main_q.receive_mode_select
            |=> flags_q.rx_full && flags_q.irq && digit_q == $past(digit_code_i);
    endproperty
    a_digit_rx: assert property (p_digit_rx) else $error("digit not received");

    property p_cp_no_digit;
        main_q.receive_mode_select && !flags_q.rx_full |=> !flags_q.rx_full;
    endproperty
    a_cp_no_digit: assert property (p_cp_no_digit) else $error("digit in call-progress mode");

    property p_read_clear;
        flags_read && !digit_valid_i && !burst_done |=> !flags_q.irq;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("flags read did not clear");

    property p_irq_or;
        flags_q.irq == (flags_q.rx_full || flags_q.tx_empty);
    endproperty
    a_irq_or: assert property (p_irq_or) else $error("interrupt flag mismatch");

    property p_burst_ready;
        burst_done && !aux_q.burst_off |=> flags_q.tx_empty && bst_q == BST_IDLE;
    endproperty
    a_burst_ready: assert property (p_burst_ready) else $error("burst end not flagged");

    property p_event_pin;
        !main_q.receive_mode_select && !aux_q.test_mode && main_q.irq_en && flags_q.irq
            |=> event_or_tone_oe_o && !event_or_tone_pin_o;
    endproperty
    a_event_pin: assert property (p_event_pin) else $error("event pin not pulled low");

    property p_tone_off;
        !main_q.tone_output_enable |=> !tone_on_o;
    endproperty
    a_tone_off: assert property (p_tone_off) else $error("tone on while disabled");

endmodule : adaptive_host_port

// ---- tb/host_cpu_model.sv ----
// Host processor model that runs register cycles on the adaptive host port pins
module host_cpu_model (
    // Clock
    input  wire logic       clk_sys_i,
    // Pins towards the device
    output logic            cs_n_o,
    output logic            strobe_o,
    output logic            rw_o,
    output logic            rs_o,
    output logic [3:0]      data_o,
    // Device answer
    input  wire logic [3:0] bus_i,
    input  wire logic       data_oe_i
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle pins: deselected, strobe style
    initial begin
        cs_n_o   = 1'b1;
        strobe_o = 1'b0;
        rw_o     = 1'b1;
        rs_o     = 1'b0;
        data_o   = 4'h0;
    end

    // One access; every access opens with a fresh chip-select fall
    task automatic access(input logic split, input logic rd, input logic rs,
                          input logic [3:0] wd, output logic [3:0] rdv);
        int n;
        @(posedge clk_sys_i);
        cs_n_o   <= 1'b0;
        strobe_o <= split;
        rw_o     <= split ? 1'b1 : rd;
        rs_o     <= rs;
        data_o   <= rd ? ~data_o : wd;
        @(posedge clk_sys_i);
        if (split && rd) begin
            strobe_o <= 1'b0;
        end else if (split) begin
            rw_o <= 1'b0;
        end else begin
            strobe_o <= 1'b1;
        end
        repeat (5) @(posedge clk_sys_i);
        n = 0;
        while (rd && data_oe_i !== 1'b1 && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        rdv = bus_i;
        strobe_o <= split;
        rw_o     <= 1'b1;
        // Data held past strobe end, then inverted
        repeat (3) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        data_o <= ~data_o;
        repeat (4) @(posedge clk_sys_i);
    endtask : access
endmodule : host_cpu_model

// ---- tb/adaptive_host_port_test.sv ----
// Self-checking bench for the adaptive host port
module adaptive_host_port_test;
    import adaptive_host_port_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic       clk_sys_i = 1'b0;
    logic       nrst_i = 1'b0;
    logic       cs_n, strobe, rw, rs;
    logic [3:0] host_data, data_o, bus, tone_code_o, v;
    logic       data_oe_o, pin_o, pin_oe, tone_on_o, single_tone_o, column_tone_o;
    logic       cp_mode_o, bus_style_o, bus_mux_o, event_line;
    logic       digit_valid_i = 1'b0;
    logic [3:0] digit_code_i = 4'h0;
    logic       steer_absent_i = 1'b1;
    logic       cp_tone_i = 1'b1;
    logic       split_style = 1'b0;
    int         mismatches = 0;
    int         compares = 0;

    // Clock, shared data lines and pulled-up event line
    always #10 clk_sys_i = ~clk_sys_i;
    assign bus = data_oe_o ? data_o : host_data;
    assign event_line = pin_oe ? pin_o : 1'b1;

    // Device and host
    adaptive_host_port #(.BURST_CYCLES(8)) uut (
        .clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .cs_n_i(cs_n),
        .bus_strobe_in_i(strobe), .rw_i(rw), .register_select_line_i(rs),
        .data_i(bus), .data_o(data_o), .data_oe_o(data_oe_o),
        .event_or_tone_pin_o(pin_o), .event_or_tone_oe_o(pin_oe),
        .digit_valid_i(digit_valid_i), .digit_code_i(digit_code_i),
        .steer_absent_i(steer_absent_i), .cp_tone_i(cp_tone_i),
        .tone_code_o(tone_code_o), .tone_on_o(tone_on_o), .single_tone_o(single_tone_o),
        .column_tone_o(column_tone_o), .cp_mode_o(cp_mode_o),
        .bus_style_o(bus_style_o), .bus_mux_o(bus_mux_o));
    host_cpu_model host (
        .clk_sys_i(clk_sys_i), .cs_n_o(cs_n), .strobe_o(strobe), .rw_o(rw),
        .rs_o(rs), .data_o(host_data), .bus_i(bus), .data_oe_i(data_oe_o));

    // Comparison and helpers
    task automatic check(input logic [3:0] got, input logic [3:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic wr(input logic sel, input logic [3:0] d);
        logic [3:0] unused;
        host.access(split_style, 1'b0, sel, d, unused);
    endtask : wr

    task automatic rd(input logic sel, output logic [3:0] r);
        host.access(split_style, 1'b1, sel, 4'h0, r);
    endtask : rd

    task automatic wait_line(input logic lvl);
        int n;
        n = 0;
        while (event_line !== lvl && n < 60) begin
            @(posedge clk_sys_i);
            n++;
        end
    endtask : wait_line

    task automatic pulse_digit(input logic [3:0] c);
        @(posedge clk_sys_i);
        digit_valid_i  <= 1'b1;
        digit_code_i   <= c;
        steer_absent_i <= 1'b0;
        @(posedge clk_sys_i);
        digit_valid_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        steer_absent_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
    endtask : pulse_digit

    task automatic wrap_up;
        $display("Counts: %0d compares, %0d mismatches", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // Scenarios
    task automatic t_reset;
        check(tone_code_o, 4'h0);
        check({tone_on_o, cp_mode_o, pin_oe, bus_style_o}, 4'h0);
        check({3'h0, pin_o}, 4'h0);
        $display("test reset done");
    endtask : t_reset

    task automatic t_init;
        split_style = STYLE_STROBE;
        wr(REG_CTRL, 4'h0);
        wr(REG_CTRL, 4'h0);
        wr(REG_CTRL, 4'h8);
        wr(REG_CTRL, 4'h0);
        check({2'h0, bus_mux_o, bus_style_o}, 4'h0);
        rd(REG_CTRL, v);
        check(v, 4'h8);
        $display("test init done");
    endtask : t_init

    task automatic t_steer;
        wr(REG_CTRL, 4'hA);
        check({3'h0, cp_mode_o}, 4'h1);
        wr(REG_CTRL, 4'hC);
        check({1'b0, column_tone_o, single_tone_o, cp_mode_o}, 4'h7);
        wr(REG_CTRL, 4'h0);
        check({1'b0, column_tone_o, single_tone_o, cp_mode_o}, 4'h6);
        $display("test steer done");
    endtask : t_steer

    task automatic t_split;
        split_style = STYLE_SPLIT;
        wr(REG_DATA, 4'h5);
        check(tone_code_o, 4'h5);
        check({2'h0, bus_mux_o, bus_style_o}, 4'h3);
        wr(REG_DATA, 4'hA);
        check(tone_code_o, 4'hA);
        $display("test split done");
    endtask : t_split

    task automatic t_tone_off;
        wr(REG_CTRL, 4'h9);
        wr(REG_CTRL, 4'h1);
        check({3'h0, tone_on_o}, 4'h1);
        wr(REG_CTRL, 4'h4);
        check({3'h0, tone_on_o}, 4'h0);
        rd(REG_CTRL, v);
        check(v, 4'h8);
        $display("test tone off done");
    endtask : t_tone_off

    task automatic t_burst;
        wr(REG_CTRL, 4'hD);
        wr(REG_CTRL, 4'h0);
        wr(REG_DATA, 4'h7);
        check({3'h0, tone_on_o}, 4'h1);
        wait_line(1'b0);
        check({3'h0, event_line}, 4'h0);
        check({3'h0, tone_on_o}, 4'h0);
        check({3'h0, pin_o}, 4'h0);
        rd(REG_CTRL, v);
        check(v, 4'hB);
        check({3'h0, event_line}, 4'h1);
        rd(REG_CTRL, v);
        check(v, 4'h8);
        $display("test burst done");
    endtask : t_burst

    task automatic t_rx;
        pulse_digit(4'h3);
        wait_line(1'b0);
        check({3'h0, event_line}, 4'h0);
        rd(REG_DATA, v);
        check(v, 4'h3);
        rd(REG_CTRL, v);
        check(v, 4'hD);
        check({3'h0, event_line}, 4'h1);
        rd(REG_DATA, v);
        check(v, 4'h3);
        $display("test receive done");
    endtask : t_rx

    task automatic t_cp;
        wr(REG_CTRL, 4'h6);
        check({3'h0, cp_mode_o}, 4'h1);
        cp_tone_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check({3'h0, event_line}, 4'h0);
        cp_tone_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check({3'h0, event_line}, 4'h1);
        pulse_digit(4'h9);
        rd(REG_DATA, v);
        check(v, 4'h3);
        rd(REG_CTRL, v);
        check(v, 4'h8);
        $display("test call progress done");
    endtask : t_cp

    // Test mode: event line mirrors the delayed steering level in tone-pair mode
    task automatic t_test;
        wr(REG_CTRL, 4'hC);
        wr(REG_CTRL, 4'h2);
        check({3'h0, event_line}, 4'h1);
        steer_absent_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
        check({3'h0, event_line}, 4'h0);
        steer_absent_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        check({3'h0, event_line}, 4'h1);
        $display("test steering pin done");
    endtask : t_test

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        wrap_up();
    end

    // Main sequence
    initial begin
        repeat (10) @(posedge clk_sys_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_sys_i);
        t_reset();
        t_init();
        t_steer();
        t_split();
        t_tone_off();
        t_burst();
        t_rx();
        t_cp();
        t_test();
        wrap_up();
    end
endmodule : adaptive_host_port_test
